// ---- pmap_pkg.sv ----
// Shared constants, types and carriers for the program memory access protection block.
package pmap_pkg;

   // ------------------------------------------------------------------
   // Address map
   // ------------------------------------------------------------------
   localparam int unsigned ADDR_W = 22;                // Table pointer reach, bytes
   localparam int unsigned EE_AW = 10;                 // Data nonvolatile array address width
   localparam logic [21:0] BOOT_END = 22'h000800;      // First byte past the boot block
   localparam logic [21:0] USER_END = 22'h010000;      // First byte past user program memory
   localparam logic [21:0] ID_FIRST = 22'h200000;      // Identification locations
   localparam logic [21:0] ID_LAST = 22'h200007;
   localparam logic [21:0] CFG_FIRST = 22'h300000;     // Configuration word space
   localparam logic [21:0] CFG_LAST = 22'h30000F;
   localparam logic [21:0] IMG_FIRST = 22'h300008;     // Protection bytes held in this block
   localparam logic [21:0] IMG_LAST = 22'h30000D;
   localparam logic [3:0] IMG_BASE_LOW = 4'h8;         // Low nibble of the first protection byte
   localparam logic [21:0] DEVID_FIRST = 22'h3FFFFE;   // Device identification word
   localparam logic [21:0] DEVID_LAST = 22'h3FFFFF;

   // ------------------------------------------------------------------
   // Blocks and protection bytes
   // ------------------------------------------------------------------
   localparam int unsigned NUM_BLK = 5;                // Four 16 Kbyte blocks plus boot block
   localparam int unsigned BLK_LSB = 14;               // Block select lsb inside user space
   localparam logic [2:0] BOOT_IDX = 3'h4;             // Index used for the boot block
   localparam int unsigned IMG_BYTES = 6;
   localparam logic [2:0] CFG_CP_L = 3'h0;             // Per-block read protect, blocks 0..3
   localparam logic [2:0] CFG_CP_H = 3'h1;             // Boot and data read protect
   localparam logic [2:0] CFG_WP_L = 3'h2;             // Per-block write protect, blocks 0..3
   localparam logic [2:0] CFG_WP_H = 3'h3;             // Boot, config and data write protect
   localparam logic [2:0] CFG_XR_L = 3'h4;             // Per-block cross read enable, 0..3
   localparam logic [2:0] CFG_XR_H = 3'h5;             // Boot cross read enable
   localparam int unsigned BOOT_BIT = 6;               // Boot bit inside each high byte
   localparam int unsigned DATA_BIT = 7;               // Data memory bit inside the CFG_CP_H and CFG_WP_H bytes
   localparam int unsigned CFGWP_BIT = 5;              // Config write protect inside WP_H
   localparam logic [7:0] ZERO_BYTE = 8'h00;

   // Implemented bits; also the erased value, unimplemented bits stay zero
   localparam logic [5:0][7:0] IMPL_ALL = 48'h40_0F_E0_0F_C0_0F;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef logic [5:0][7:0] pmap_cfg_t;

   typedef enum logic [2:0] {
      RG_USER = 3'h0,
      RG_UNIMPL = 3'h1,
      RG_ID = 3'h2,
      RG_CFG = 3'h3,
      RG_DEVID = 3'h4
   } pmap_region_t;

   typedef enum logic [1:0] {
      OP_READ = 2'h0,
      OP_WRITE = 2'h1,
      OP_ERASE = 2'h2
   } pmap_op_t;

   typedef enum logic [1:0] {
      SRC_TBL = 2'h0,
      SRC_EE = 2'h1,
      SRC_PROG = 2'h2
   } pmap_src_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ISSUE = 2'b01,
      ST_WAIT = 2'b11,
      ST_DONE = 2'b10
   } pmap_state_t;

   // Request held while it is served
   typedef struct packed {
      pmap_src_t src;
      pmap_op_t op;
      logic ee;
      logic all;
      logic [21:0] addr;
      logic [7:0] wdata;
   } pmap_req_t;

   // Command to the memory arrays
   typedef struct packed {
      logic req;
      pmap_op_t op;
      logic ee;
      logic all;
      logic [21:0] addr;
      logic [7:0] wdata;
   } pmap_mem_t;

endpackage : pmap_pkg

// ---- pmap_region_decode.sv ----
// Address decoder: region and protection block of a table address.
`timescale 1ns/1ps
`default_nettype none

module pmap_region_decode (
   input wire logic [21:0] addr_i,
   output pmap_pkg::pmap_region_t region_o,
   output logic [2:0] blk_o
);

   // ------------------------------------------------------------------
   // Block index: boot block below its end, else the 16 Kbyte slice
   // ------------------------------------------------------------------
   always_comb begin
      if (addr_i < pmap_pkg::BOOT_END) begin
         blk_o = pmap_pkg::BOOT_IDX;
      end else begin
         blk_o = {1'b0, addr_i[pmap_pkg::BLK_LSB+1:pmap_pkg::BLK_LSB]};
      end
   end

   // ------------------------------------------------------------------
   // Region select
   // ------------------------------------------------------------------
   always_comb begin
      if (addr_i < pmap_pkg::USER_END) begin
         region_o = pmap_pkg::RG_USER;
      end else if (addr_i >= pmap_pkg::ID_FIRST && addr_i <= pmap_pkg::ID_LAST) begin
         region_o = pmap_pkg::RG_ID;
      end else if (addr_i >= pmap_pkg::CFG_FIRST && addr_i <= pmap_pkg::CFG_LAST) begin
         region_o = pmap_pkg::RG_CFG;
      end else if (addr_i >= pmap_pkg::DEVID_FIRST && addr_i <= pmap_pkg::DEVID_LAST) begin
         region_o = pmap_pkg::RG_DEVID;
      end else begin
         region_o = pmap_pkg::RG_UNIMPL;
      end
   end

endmodule : pmap_region_decode

`default_nettype wire

// ---- pmap_top.sv ----
// Program memory access protection: gates table, data memory and programmer accesses.
//
// How it works
// RQ1: Read protect blocks only programmer accesses.
// RQ2: Write protect clear refuses table writes.
// RQ3: Same-block table reads see true data.
// RQ4: Cross-block reads return zeros when disabled.
// RQ5: Protection bits only go one to zero.
// RQ6: Only programmer erase sets bits again.
// RQ7: Data protect bits gate programmer data accesses.
// RQ8: Processor data memory reads always succeed.
// RQ9: Config write protect guards config; user read-only.
// RQ10: Eight ID bytes reachable by all.
// RQ11: ID bytes readable despite protection.
// RQ12: Table reaches device ID and config.
// RQ13: Boot block plus four 16 Kbyte blocks.
// RQ14: Refused table writes leave memory untouched.
// RQ15: Instruction fetches ignore all protection.
`timescale 1ns/1ps
`default_nettype none

module pmap_top (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire pmap_pkg::pmap_cfg_t nv_cfg_i,
   input wire logic prog_mode_i,
   input wire logic tbl_req_i,
   input wire logic tbl_we_i,
   input wire logic [21:0] tbl_addr_i,
   input wire logic [7:0] tbl_wdata_i,
   input wire logic [21:0] instr_addr_i,
   input wire logic ee_req_i,
   input wire logic [9:0] ee_addr_i,
   input wire logic prog_req_i,
   input wire pmap_pkg::pmap_op_t prog_op_i,
   input wire logic prog_ee_i,
   input wire logic prog_all_i,
   input wire logic [21:0] prog_addr_i,
   input wire logic [7:0] prog_wdata_i,
   input wire logic fetch_req_i,
   input wire logic [21:0] fetch_addr_i,
   input wire logic [7:0] mem_rdata_i,
   output pmap_pkg::pmap_mem_t mem_o,
   output logic fetch_req_o,
   output logic [21:0] fetch_addr_o,
   output logic [7:0] rsp_data_o,
   output logic tbl_ack_o,
   output logic ee_ack_o,
   output logic prog_ack_o,
   output logic refused_o,
   output pmap_pkg::pmap_cfg_t cfg_image_o,
   output logic cfg_wp_o,
   output logic ready_o
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   pmap_pkg::pmap_state_t st_q, st_d;        // Access sequencer
   pmap_pkg::pmap_req_t req_q, req_d;        // Request being served
   pmap_pkg::pmap_cfg_t cfg_q, cfg_d;        // Protection bytes
   logic [7:0] data_q, data_d;               // Answer data
   logic ref_q, ref_d;                       // Answer refused
   logic loaded_q;                           // Protection image taken from storage

   // Arbitration and decisions
   pmap_pkg::pmap_req_t cand;                // Request offered this cycle
   logic take;                               // Request accepted
   pmap_pkg::pmap_region_t rg, irg;          // Target and instruction regions
   logic [2:0] blk, iblk;                    // Target and instruction blocks
   localparam int unsigned NB = pmap_pkg::NUM_BLK;
   logic [NB-1:0] rp, wp, xr;                // Per-block protection views
   logic dm_rp, dm_wp, cfgwp;                // Data and config protection
   logic go_mem, refuse, zero_rd;            // Decision of the offered request
   logic img_hit, erase_blk, erase_all;
   logic [2:0] idx;                          // Protection byte index
   logic [7:0] wmask;                        // Writable bits of that byte

   // ------------------------------------------------------------------
   // Per-block views of the protection bytes
   // ------------------------------------------------------------------
   for (genvar k = 0; k < NB; k++) begin : g_blk
      if (k < NB - 1) begin : g_main
         assign rp[k] = cfg_q[pmap_pkg::CFG_CP_L][k];
         assign wp[k] = cfg_q[pmap_pkg::CFG_WP_L][k];
         assign xr[k] = cfg_q[pmap_pkg::CFG_XR_L][k];
      end else begin : g_boot                                      // [RQ13]
         assign rp[k] = cfg_q[pmap_pkg::CFG_CP_H][pmap_pkg::BOOT_BIT];
         assign wp[k] = cfg_q[pmap_pkg::CFG_WP_H][pmap_pkg::BOOT_BIT];
         assign xr[k] = cfg_q[pmap_pkg::CFG_XR_H][pmap_pkg::BOOT_BIT];
      end
   end
   assign dm_rp = cfg_q[pmap_pkg::CFG_CP_H][pmap_pkg::DATA_BIT];
   assign dm_wp = cfg_q[pmap_pkg::CFG_WP_H][pmap_pkg::DATA_BIT];
   assign cfgwp = cfg_q[pmap_pkg::CFG_WP_H][pmap_pkg::CFGWP_BIT];

   // ------------------------------------------------------------------
   // Arbiter: programmer in program mode, else table, else data reads
   // ------------------------------------------------------------------
   always_comb begin
      take = 1'b0;
      cand = req_q;
      if (st_q == pmap_pkg::ST_IDLE && loaded_q) begin
         if (prog_mode_i && prog_req_i) begin
            take = 1'b1;
            cand = '{pmap_pkg::SRC_PROG, prog_op_i, prog_ee_i, prog_all_i, prog_addr_i, prog_wdata_i};
         end else if (!prog_mode_i && tbl_req_i) begin
            take = 1'b1;
            cand = '{pmap_pkg::SRC_TBL, tbl_we_i ? pmap_pkg::OP_WRITE : pmap_pkg::OP_READ,
                     1'b0, 1'b0, tbl_addr_i, tbl_wdata_i};
         end else if (ee_req_i) begin
            take = 1'b1;
            cand = '{pmap_pkg::SRC_EE, pmap_pkg::OP_READ, 1'b1, 1'b0, {12'h000, ee_addr_i}, 8'h00};
         end
      end
   end

   // Target address and the address of the issuing instruction
   pmap_region_decode u_tgt_dec (
      .addr_i(cand.addr),
      .region_o(rg),
      .blk_o(blk)
   );

   pmap_region_decode u_ins_dec (
      .addr_i(instr_addr_i),
      .region_o(irg),
      .blk_o(iblk)
   );

   assign idx = 3'(cand.addr[3:0] - pmap_pkg::IMG_BASE_LOW);
   assign img_hit = cand.addr >= pmap_pkg::IMG_FIRST && cand.addr <= pmap_pkg::IMG_LAST;

   // ------------------------------------------------------------------
   // Access decision for the offered request
   // ------------------------------------------------------------------
   always_comb begin
      go_mem = 1'b0;
      refuse = 1'b0;
      zero_rd = 1'b0;
      erase_blk = 1'b0;
      erase_all = 1'b0;
      if (cand.ee) begin
         if (cand.src == pmap_pkg::SRC_PROG) begin
            refuse = !dm_rp || (cand.op != pmap_pkg::OP_READ && !dm_wp);      // [RQ7]
         end
         go_mem = !refuse;                                                     // [RQ8]
      end else if (cand.op == pmap_pkg::OP_ERASE) begin
         // Only the programmer port can carry an erase
         erase_all = cand.all;                                                 // [RQ6]
         erase_blk = !cand.all && rg == pmap_pkg::RG_USER;                     // [RQ6]
         refuse = !cand.all && rg != pmap_pkg::RG_USER;
         go_mem = !refuse;
      end else begin
         case (rg)
            pmap_pkg::RG_USER: begin
               if (cand.src == pmap_pkg::SRC_PROG) begin
                  refuse = !rp[blk];                                           // [RQ1]
               end else if (cand.op == pmap_pkg::OP_WRITE) begin
                  refuse = !wp[blk];                                           // [RQ2] [RQ14]
               end else begin
                  zero_rd = !xr[blk] && !(irg == pmap_pkg::RG_USER && iblk == blk);  // [RQ3] [RQ4]
               end
               go_mem = !refuse && !zero_rd;
            end
            pmap_pkg::RG_ID: begin
               go_mem = 1'b1;                                                  // [RQ10] [RQ11]
            end
            pmap_pkg::RG_CFG: begin
               if (cand.op == pmap_pkg::OP_WRITE && cand.src == pmap_pkg::SRC_TBL && !cfgwp) begin
                  refuse = 1'b1;                                               // [RQ9] [RQ12]
               end else begin
                  go_mem = !img_hit;                                           // [RQ12]
               end
            end
            pmap_pkg::RG_DEVID: begin
               refuse = cand.op == pmap_pkg::OP_WRITE;
               go_mem = !refuse;                                               // [RQ12]
            end
            default: begin
               // Unimplemented space reads zero, writes go nowhere
               refuse = cand.op == pmap_pkg::OP_WRITE;
               zero_rd = !refuse;
            end
         endcase
      end
   end

   // User writes may never touch the config write protect bit
   always_comb begin
      wmask = pmap_pkg::IMPL_ALL[idx];
      if (cand.src == pmap_pkg::SRC_TBL && idx == pmap_pkg::CFG_WP_H) begin
         wmask[pmap_pkg::CFGWP_BIT] = 1'b0;                                    // [RQ9]
      end
   end

   // ------------------------------------------------------------------
   // Next state of the sequencer and protection bytes
   // ------------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      req_d = req_q;
      cfg_d = cfg_q;
      data_d = data_q;
      ref_d = ref_q;
      if (!loaded_q) begin
         cfg_d = nv_cfg_i & pmap_pkg::IMPL_ALL;
      end
      case (st_q)
         pmap_pkg::ST_IDLE: begin
            if (take) begin
               req_d = cand;
               ref_d = refuse;
               data_d = pmap_pkg::ZERO_BYTE;                                   // [RQ4]
               if (rg == pmap_pkg::RG_CFG && img_hit && !refuse && !cand.ee) begin
                  if (cand.op == pmap_pkg::OP_WRITE) begin
                     // A written one cannot raise a cleared bit
                     cfg_d[idx] = cfg_q[idx] & (cand.wdata | ~wmask);          // [RQ5]
                  end else begin
                     data_d = cfg_q[idx];                                      // [RQ12]
                  end
               end
               if (erase_all) begin
                  cfg_d = pmap_pkg::IMPL_ALL;                                  // [RQ6]
               end else if (erase_blk) begin
                  for (int j = 0; j < 3; j++) begin
                     if (blk == pmap_pkg::BOOT_IDX) begin
                        cfg_d[2*j+1][pmap_pkg::BOOT_BIT] = 1'b1;               // [RQ6]
                     end else begin
                        cfg_d[2*j][blk[1:0]] = 1'b1;                           // [RQ6]
                     end
                  end
               end
               st_d = go_mem ? pmap_pkg::ST_ISSUE : pmap_pkg::ST_DONE;        // [RQ14]
            end
         end
         pmap_pkg::ST_ISSUE: begin
            st_d = pmap_pkg::ST_WAIT;
         end
         pmap_pkg::ST_WAIT: begin
            data_d = mem_rdata_i;
            st_d = pmap_pkg::ST_DONE;
         end
         default: begin
            st_d = pmap_pkg::ST_IDLE;
         end
      endcase
   end

   // Registers; the image is erased-state until storage is copied in
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_q <= pmap_pkg::ST_IDLE;
         req_q <= '0;
         cfg_q <= pmap_pkg::IMPL_ALL;
         data_q <= pmap_pkg::ZERO_BYTE;
         ref_q <= 1'b0;
         loaded_q <= 1'b0;
      end else begin
         st_q <= st_d;
         req_q <= req_d;
         cfg_q <= cfg_d;
         data_q <= data_d;
         ref_q <= ref_d;
         loaded_q <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign mem_o = '{st_q == pmap_pkg::ST_ISSUE, req_q.op, req_q.ee, req_q.all, req_q.addr, req_q.wdata};
   assign fetch_req_o = fetch_req_i;                                           // [RQ15]
   assign fetch_addr_o = fetch_addr_i;                                         // [RQ15]
   assign rsp_data_o = data_q;
   assign tbl_ack_o = st_q == pmap_pkg::ST_DONE && req_q.src == pmap_pkg::SRC_TBL;
   assign ee_ack_o = st_q == pmap_pkg::ST_DONE && req_q.src == pmap_pkg::SRC_EE;
   assign prog_ack_o = st_q == pmap_pkg::ST_DONE && req_q.src == pmap_pkg::SRC_PROG;
   assign refused_o = st_q == pmap_pkg::ST_DONE && ref_q;
   assign cfg_image_o = cfg_q;
   assign cfg_wp_o = cfgwp;                                                    // [RQ9]
   assign ready_o = loaded_q;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);

   logic tk_tbl;
   logic erase_now;
   assign tk_tbl = take && cand.src == pmap_pkg::SRC_TBL;
   assign erase_now = take && (erase_all || erase_blk);

   property p_rq1;
      take && cand.src == pmap_pkg::SRC_PROG && !cand.ee && cand.op != pmap_pkg::OP_ERASE
         && rg == pmap_pkg::RG_USER && !rp[blk] |=> prog_ack_o && refused_o && rsp_data_o == 8'h00;
   endproperty
   a_rq1: assert property (p_rq1) else $error("programmer reached a read protected block"); // [RQ1]

   property p_rq2;
      tk_tbl && cand.op == pmap_pkg::OP_WRITE && rg == pmap_pkg::RG_USER && !wp[blk]
         |=> tbl_ack_o && refused_o && !mem_o.req ##1 st_q == pmap_pkg::ST_IDLE;
   endproperty
   a_rq2: assert property (p_rq2) else $error("protected table write not refused"); // [RQ2]

   property p_rq3;
      tk_tbl && cand.op == pmap_pkg::OP_READ && rg == pmap_pkg::RG_USER && irg == pmap_pkg::RG_USER
         && iblk == blk |=> mem_o.req ##1 1'b1 ##1 tbl_ack_o && rsp_data_o == $past(mem_rdata_i);
   endproperty
   a_rq3: assert property (p_rq3) else $error("same-block table read lost data"); // [RQ3]

   property p_rq4;
      tk_tbl && zero_rd && rg == pmap_pkg::RG_USER |=> tbl_ack_o && rsp_data_o == 8'h00 && !mem_o.req;
   endproperty
   a_rq4: assert property (p_rq4) else $error("cross-block read not zeroed"); // [RQ4]

   property p_rq5;
      loaded_q && !erase_now |=> (cfg_q & ~$past(cfg_q)) == '0;
   endproperty
   a_rq5: assert property (p_rq5) else $error("protection bit raised without erase"); // [RQ5]

   property p_rq6;
      erase_now |-> prog_mode_i && prog_req_i && prog_op_i == pmap_pkg::OP_ERASE && !prog_ee_i;
   endproperty
   a_rq6: assert property (p_rq6) else $error("erase not from programmer"); // [RQ6]

   property p_rq7;
      mem_o.req && mem_o.ee && mem_o.op != pmap_pkg::OP_READ |-> dm_rp && dm_wp;
   endproperty
   a_rq7: assert property (p_rq7) else $error("protected data memory written"); // [RQ7]

   property p_rq8;
      take && cand.src == pmap_pkg::SRC_EE |=> mem_o.req ##2 ee_ack_o && !refused_o;
   endproperty
   a_rq8: assert property (p_rq8) else $error("processor data read blocked"); // [RQ8]

   property p_rq9;
      tk_tbl |=> $stable(cfgwp);
   endproperty
   a_rq9: assert property (p_rq9) else $error("user code changed config write protect"); // [RQ9]

   property p_rq11;
      take && rg == pmap_pkg::RG_ID && cand.op == pmap_pkg::OP_READ && !cand.ee |=> mem_o.req;
   endproperty
   a_rq11: assert property (p_rq11) else $error("ID read blocked"); // [RQ11]

   c_zero_read: cover property (tk_tbl && zero_rd);
   c_refused_write: cover property (tk_tbl && refuse && cand.op == pmap_pkg::OP_WRITE);
   c_block_erase: cover property (erase_blk && take);
   c_ee_read: cover property (ee_ack_o);

endmodule : pmap_top

`default_nettype wire

// ---- pmap_mem_model.sv ----
// Memory array stand-in that answers the access block one cycle after each command.
`timescale 1ns/1ps
`default_nettype none

module pmap_mem_model (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire pmap_pkg::pmap_mem_t mem_i,
   output logic [7:0] rdata_o
);
   logic [7:0] rdata_d;
   // Data follows the address; without a command it toggles, so stale data never matches
   always_comb begin
      rdata_d = ~rdata_o;
      if (mem_i.req) rdata_d = mem_i.addr[7:0] ^ 8'hA5;
   end
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) rdata_o <= 8'h00;
      else rdata_o <= rdata_d;
   end
endmodule : pmap_mem_model
`default_nettype wire

// ---- test_pmap_top.sv ----
// Self-checking bench for the program memory access protection block.
`timescale 1ns/1ps
`default_nettype none

module test_pmap_top;
   logic ref_clk_i, nrst_i, prog_mode_i, tbl_req_i, tbl_we_i, ee_req_i, prog_req_i, prog_ee_i, prog_all_i;
   logic fetch_req_i, fetch_req_o, tbl_ack_o, ee_ack_o, prog_ack_o, refused_o, cfg_wp_o, ready_o, w;
   logic [21:0] tbl_addr_i, instr_addr_i, prog_addr_i, fetch_addr_i, fetch_addr_o, a, ia;
   logic [9:0] ee_addr_i;
   logic [7:0] tbl_wdata_i, prog_wdata_i, mem_rdata_i, rsp_data_o;
   pmap_pkg::pmap_cfg_t nv_cfg_i, cfg_image_o, cm;
   pmap_pkg::pmap_op_t prog_op_i;
   pmap_pkg::pmap_mem_t mem_o;
   int err_count, n_checks, mcnt, s, seed = 52370;

   pmap_top i_dut (.*);
   pmap_mem_model i_mem (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .mem_i(mem_o), .rdata_o(mem_rdata_i));

   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   // Counts memory commands so a task can tell whether an access reached the array
   always @(posedge ref_clk_i) if (mem_o.req === 1'b1) mcnt <= mcnt + 1;

   task chk(input logic c, input string m);
      n_checks++;
      if (c !== 1'b1) begin
         err_count++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : chk
   task test_done;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : test_done

   // Reset with a stored protection image, then check the loaded image
   task automatic rst(input pmap_pkg::pmap_cfg_t c);
      @(posedge ref_clk_i);
      nrst_i <= 1'b0;
      nv_cfg_i <= c;
      cm = c & pmap_pkg::IMPL_ALL;
      repeat (2) @(posedge ref_clk_i);
      chk(cfg_image_o === pmap_pkg::IMPL_ALL && ready_o === 1'b0, "reset image");
      nrst_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      #1 chk(ready_o === 1'b1 && cfg_image_o === cm, "loaded image");
      chk(cfg_wp_o === cm[pmap_pkg::CFG_WP_H][pmap_pkg::CFGWP_BIT], "config flag");
   endtask : rst

   // One access; e holds refused, memory used (x = any) and read data
   task automatic acc(input int s, input pmap_pkg::pmap_op_t op, input logic [21:0] a, ia,
                      input logic [7:0] wd, input logic [9:0] e);
      int n, m0;
      @(posedge ref_clk_i);
      m0 = mcnt;
      {tbl_addr_i, prog_addr_i, instr_addr_i, ee_addr_i} <= {a, a, ia, a[9:0]};
      {tbl_wdata_i, prog_wdata_i, prog_op_i} <= {wd, wd, op};
      {tbl_we_i, prog_ee_i, prog_mode_i} <= {op == pmap_pkg::OP_WRITE, s == 3, s >= 2};
      {tbl_req_i, ee_req_i, prog_req_i} <= {s == 0, s == 1, s >= 2};
      n = 0;
      do begin
         @(posedge ref_clk_i);
         #1 n++;
      end while (!(tbl_ack_o | ee_ack_o | prog_ack_o) && n < 20);
      chk(n < 20, "no answer");
      if (n >= 20) test_done();
      chk({tbl_ack_o, ee_ack_o, prog_ack_o} === {s == 0, s == 1, s >= 2}, "answer port");
      chk(refused_o === e[9], "refused flag");
      if (op == pmap_pkg::OP_READ || e[9]) chk(rsp_data_o === e[7:0], "answer data");
      if (e[8] !== 1'bx) chk((mcnt != m0) === e[8], "memory command");
      @(posedge ref_clk_i);
      {tbl_req_i, ee_req_i, prog_req_i} <= 3'h0;
   endtask : acc

   function automatic logic [2:0] bi(input logic [21:0] a);
      return a < pmap_pkg::BOOT_END ? 3'h4 : {1'b0, a[15:14]};
   endfunction : bi
   function automatic logic pb(input logic [2:0] y, input logic [21:0] a);
      return bi(a) == 3'h4 ? cm[y + 3'h1][pmap_pkg::BOOT_BIT] : cm[y][bi(a)];
   endfunction : pb
   // Expected outcome: 0 table, 1 processor data read, 2 programmer user, 3 programmer data
   function automatic logic [9:0] ex(input int s, input logic w, input logic [21:0] a, ia);
      logic ok;
      case (s)
         0: ok = w ? pb(pmap_pkg::CFG_WP_L, a) : pb(pmap_pkg::CFG_XR_L, a) || (ia < pmap_pkg::USER_END && bi(ia) == bi(a));
         1: ok = 1'b1;
         2: ok = pb(pmap_pkg::CFG_CP_L, a);
         default: ok = cm[pmap_pkg::CFG_CP_H][7] && (!w || cm[pmap_pkg::CFG_WP_H][7]);
      endcase
      return {!ok && (w || s > 0), ok, ok && !w ? a[7:0] ^ 8'hA5 : 8'h00};
   endfunction : ex

   initial begin
      {nrst_i, prog_mode_i, tbl_req_i, tbl_we_i, ee_req_i, prog_req_i, prog_ee_i, prog_all_i, fetch_req_i} = '0;
      {tbl_addr_i, instr_addr_i, prog_addr_i, fetch_addr_i, ee_addr_i, tbl_wdata_i, prog_wdata_i} = '0;
      nv_cfg_i = '0;
      prog_op_i = pmap_pkg::OP_READ;
      for (int r = 0; r < 3; r++) begin
         rst(r == 0 ? 48'h0 : 48'({$random(seed), $random(seed)}));
         for (int i = 0; i < 40; i++) begin
            s = {$random(seed)} % 4;
            w = $random(seed) && s != 1;
            a = $random(seed);
            a = s[0] ? {12'h000, a[9:0]} : {6'h00, a[15:0]};
            ia = 22'($random(seed)) & 22'h01FFFF;
            {fetch_req_i, fetch_addr_i} <= 23'($random(seed));
            acc(s, w ? pmap_pkg::OP_WRITE : pmap_pkg::OP_READ, a, ia, 8'($random(seed)), ex(s, w, a, ia));
            chk(fetch_req_o === fetch_req_i && fetch_addr_o === fetch_addr_i, "fetch path");
         end
         acc(0, pmap_pkg::OP_READ, 22'h000010, 22'h000700, 8'h00, {2'b01, 8'hB5});
         acc(0, pmap_pkg::OP_READ, 22'h200003, 22'h3F0000, 8'h00, {2'b01, 8'hA6});
         acc(0, pmap_pkg::OP_WRITE, pmap_pkg::ID_LAST, 22'h0, 8'h5A, {2'b01, 8'h00});
         acc(2, pmap_pkg::OP_READ, pmap_pkg::ID_LAST, 22'h0, 8'h00, {2'b01, 8'hA2});
         acc(0, pmap_pkg::OP_READ, pmap_pkg::DEVID_FIRST, 22'h0, 8'h00, {2'b01, 8'h5B});
      end
      rst(pmap_pkg::IMPL_ALL);
      for (int j = 0; j < 2; j++) begin
         acc(0, pmap_pkg::OP_WRITE, 22'h30000A, 22'h0, j ? 8'h0F : 8'h0A, {1'b0, 1'bx, 8'h00});
         chk(cfg_image_o[pmap_pkg::CFG_WP_L] === 8'h0A, "bits only clear");
      end
      acc(0, pmap_pkg::OP_READ, 22'h30000A, 22'h0, 8'h00, {2'b00, 8'h0A});
      acc(0, pmap_pkg::OP_WRITE, 22'h30000B, 22'h0, 8'h00, {1'b0, 1'bx, 8'h00});
      chk(cfg_image_o[pmap_pkg::CFG_WP_H] === 8'h20 && cfg_wp_o === 1'b1, "user config flag");
      acc(0, pmap_pkg::OP_WRITE, 22'h000900, 22'h0, 8'h11, {2'b10, 8'h00});
      // Erase is started only from the programmer side
      acc(2, pmap_pkg::OP_ERASE, 22'h000900, 22'h0, 8'h00, {2'b01, 8'h00});
      chk(cfg_image_o[pmap_pkg::CFG_WP_L] === 8'h0B, "block erase");
      acc(0, pmap_pkg::OP_WRITE, 22'h000900, 22'h0, 8'h11, {2'b01, 8'h00});
      prog_all_i <= 1'b1;
      acc(2, pmap_pkg::OP_ERASE, 22'h000000, 22'h0, 8'h00, {2'b01, 8'h00});
      chk(cfg_image_o === pmap_pkg::IMPL_ALL, "chip erase");
      prog_all_i <= 1'b0;
      acc(2, pmap_pkg::OP_WRITE, 22'h30000B, 22'h0, 8'hDF, {1'b0, 1'bx, 8'h00});
      chk(cfg_wp_o === 1'b0, "programmer config flag");
      acc(0, pmap_pkg::OP_WRITE, pmap_pkg::CFG_FIRST, 22'h0, 8'h00, {2'b10, 8'h00});
      acc(0, pmap_pkg::OP_READ, 22'h010000, 22'h0, 8'h00, {2'b00, 8'h00});
      acc(0, pmap_pkg::OP_WRITE, pmap_pkg::DEVID_LAST, 22'h0, 8'h00, {2'b10, 8'h00});
      acc(2, pmap_pkg::OP_ERASE, pmap_pkg::ID_FIRST, 22'h0, 8'h00, {2'b10, 8'h00});
      test_done();
   end
endmodule : test_pmap_top
`default_nettype wire
